//--- hdl/pcfg_pkg.sv
// shared constants and types of the port direction / pull-up control block
// assumes one system clock and a byte-wide cpu register bus
`default_nettype none
package pcfg_pkg;
  // controlled ports in slot order: 0,2,3,4,5,6,7,12,13,14
  localparam int NPORT = 10;
  localparam int NPU   = 4;
  localparam int NSEG  = 2;
  localparam int SLOT_P0  = 0;
  localparam int SLOT_P13 = 8;
  localparam int SLOT_P14 = 9;

  localparam logic [15:0] DIR_ADDR [NPORT] = '{16'hFF20, 16'hFF22, 16'hFF23, 16'hFF24,
    16'hFF25, 16'hFF26, 16'hFF27, 16'hFF2C, 16'hFF2D, 16'hFF2E};
  localparam logic [7:0]  DIR_FIXED1 [NPORT] = '{8'h00, 8'h80, 8'hE0, 8'h00, 8'h00,
    8'h4F, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0]  DIR_RESET = 8'hFF;

  // output latches, addressed at base plus port number
  localparam logic [15:0] LATCH_ADDR [NPORT] = '{16'hFF00, 16'hFF02, 16'hFF03, 16'hFF04,
    16'hFF05, 16'hFF06, 16'hFF07, 16'hFF0C, 16'hFF0D, 16'hFF0E};
  localparam logic [7:0]  LATCH_RESET = 8'h00;
  localparam logic [15:0] PORT1_ADDR  = 16'hFF01;

  localparam logic [15:0] PU_ADDR [NPU] = '{16'hFF30, 16'hFF34, 16'hFF37, 16'hFF3D};
  localparam int          PU_SLOT [NPU] = '{0, 3, 6, 8};
  localparam logic [7:0]  PU_RESET = 8'h00;

  localparam logic [15:0] SEG_ADDR [NSEG] = '{16'hFF5D, 16'hFF5E};
  localparam logic [7:0]  SEG_RESET = 8'h00;
  localparam logic [7:0]  SEG_ALL   = 8'hFF;
  localparam logic [7:0]  SEG_NONE  = 8'h00;

  typedef struct packed {
    logic [15:0] addr;   // register address
    logic        wr;     // write strobe, one cycle
    logic        rd;     // read strobe, one cycle
    logic        bitOp;  // single-bit write
    logic [2:0]  bitSel; // bit number for a single-bit write
    logic [7:0]  wdata;  // byte data; bit writes use wdata[0]
  } pcfg_sfr_req_t;

  typedef logic [NPORT-1:0][7:0] pcfg_pins_t;
endpackage
`default_nettype wire

//--- hdl/pcfg_sfr_reg.sv
// one byte-wide control register on the cpu register bus
// assumes requests are synchronous to clk_sys
`default_nettype none
module pcfg_sfr_reg #(
  parameter logic [15:0] ADDR       = 16'h0000,
  parameter logic [7:0]  RST        = 8'h00,
  parameter logic [7:0]  FIXED1     = 8'h00,
  parameter bit          WHOLE_ONLY = 1'b0
) (
  input  wire logic                   clk_sys, // system clock
  input  wire logic                   rst_n,   // synchronous reset, low
  input  wire pcfg_pkg::pcfg_sfr_req_t req,    // bus request
  output logic                        hit,     // address matches
  output logic [7:0]                  q        // register contents
);
  logic [7:0] bitMask;
  logic [7:0] byteVal;
  logic [7:0] nextVal;
  logic       legalVal;
  logic       wrEn;

  assign hit      = (req.addr == ADDR);
  assign bitMask  = 8'h01 << req.bitSel;
  assign byteVal  = req.bitOp ? ((q & ~bitMask) | ({8{req.wdata[0]}} & bitMask)) : req.wdata;
  assign nextVal  = byteVal | FIXED1; // R20
  // whole-only registers take just all-zero or all-one bytes
  assign legalVal = !WHOLE_ONLY || (!req.bitOp &&
                    (req.wdata == pcfg_pkg::SEG_NONE || req.wdata == pcfg_pkg::SEG_ALL)); // R17
  assign wrEn     = hit && req.wr && legalVal; // R3

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= RST;
    end else if (wrEn) begin
      q <= nextVal;
    end
  end
endmodule
`default_nettype wire

//--- hdl/pcfg_port_pad.sv
// pad steering of one 8-pin port: buffer enable, driven level, read value
// assumes pin levels arrive synchronous to the system clock
`default_nettype none
module pcfg_port_pad (
  input  wire logic [7:0] latchQ,  // output latch
  input  wire logic [7:0] dirQ,    // direction, 1 = input
  input  wire logic [7:0] segSel,  // segment routing per pin
  input  wire logic [7:0] segData, // segment drive level
  input  wire logic [7:0] pinIn,   // pin level
  output logic      [7:0] pinOut,  // level driven when enabled
  output logic      [7:0] pinOe,   // output buffer on
  output logic      [7:0] readVal  // value seen by a port read
);
  assign pinOe   = segSel | ~dirQ;                           // R1 R19
  assign pinOut  = (segSel & segData) | (~segSel & latchQ);  // R17 R19
  assign readVal = (dirQ & pinIn) | (~dirQ & latchQ);        // R18
endmodule
`default_nettype wire

//--- hdl/pcfg_port_ctrl.sv
// port direction, pull-up select and segment routing for the controlled ports
// assumes a byte-wide cpu register bus with one-cycle strobes and sync pins
// How it works
// R1: direction 0 drives pin, 1 floats it
// R2: reset loads all direction registers with ones
// R3: bit and byte writes, each register separate
// R4: reset clears all pull-up select registers
// R5: pull-up select 1 connects the pull-up
// R6: pull-up follows select bit, ignores direction
// R7: software clears pull-ups on output pins
// R8: port 13 has eight latched bidirectional pins
// R9: port 13 pull-up per pin select bit
// R10: port 14 latched bidirectional, no pull-ups
// R11: reset puts ports 13, 14 in input
// R12: software sets segment select before segment use
// R13: port 1 is input only
// R14: port 0 level change raises interrupt request
// R15: software masks port 0 interrupt for output
// R16: software sets direction, latch for alternates
// R17: segment select routes pins; only 00/FF
// R18: read gives pin or latch, never alters
// R19: write updates latch; pin only when driving
// R20: fixed direction bits read one, ignore writes
`default_nettype none
module pcfg_port_ctrl (
  input  wire logic                    clk_sys,     // system clock 100 MHz
  input  wire logic                    rst_n,       // synchronous reset, low
  input  wire pcfg_pkg::pcfg_sfr_req_t sfrReq,      // cpu register request
  output logic [7:0]                   sfrRdata,    // read data
  output logic                         sfrRdValid,  // read data valid pulse
  input  wire pcfg_pkg::pcfg_pins_t    pinIn,       // pin levels per slot
  output pcfg_pkg::pcfg_pins_t         pinOut,      // pin drive levels
  output pcfg_pkg::pcfg_pins_t         pinOe,       // pin output enables
  input  wire logic [7:0]              port1Pins,   // input-only port 1
  output logic [pcfg_pkg::NPU-1:0][7:0] pullupEn,   // pull-up connects 0,4,7,13
  input  wire logic [7:0]              segData13,   // segment levels for port 13
  input  wire logic [7:0]              segData14,   // segment levels for port 14
  output logic [7:0]                   port0IntReq  // port 0 change request pulses
);
  pcfg_pkg::pcfg_pins_t dirQ;
  pcfg_pkg::pcfg_pins_t latchQ;
  pcfg_pkg::pcfg_pins_t readVal;
  pcfg_pkg::pcfg_pins_t segSel;
  pcfg_pkg::pcfg_pins_t segDrive;
  logic [pcfg_pkg::NPU-1:0][7:0]  puQ;
  logic [pcfg_pkg::NSEG-1:0][7:0] segQ;
  logic [pcfg_pkg::NPORT-1:0]     dirHit;
  logic [pcfg_pkg::NPORT-1:0]     latchHit;
  logic [pcfg_pkg::NPU-1:0]       puHit;
  logic [pcfg_pkg::NSEG-1:0]      segHit;
  logic                           port1Hit;
  logic [7:0]                     rdata_d;
  logic [7:0]                     rdata_q;
  logic                           rdValid_q;
  logic [7:0]                     p0Prev_q;
  logic                           p0Primed_q;
  logic [7:0]                     intReq_q;

  genvar g;
  generate
    for (g = 0; g < pcfg_pkg::NPORT; g++) begin : gPort
      pcfg_sfr_reg #(
        .ADDR   (pcfg_pkg::DIR_ADDR[g]),
        .RST    (pcfg_pkg::DIR_RESET),
        .FIXED1 (pcfg_pkg::DIR_FIXED1[g])
      ) uDir (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .req     (sfrReq),
        .hit     (dirHit[g]),
        .q       (dirQ[g])
      ); // R2 R3 R8 R10 R11 R20

      pcfg_sfr_reg #(
        .ADDR (pcfg_pkg::LATCH_ADDR[g]),
        .RST  (pcfg_pkg::LATCH_RESET)
      ) uLatch (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .req     (sfrReq),
        .hit     (latchHit[g]),
        .q       (latchQ[g])
      ); // R19

      pcfg_port_pad uPad (
        .latchQ  (latchQ[g]),
        .dirQ    (dirQ[g]),
        .segSel  (segSel[g]),
        .segData (segDrive[g]),
        .pinIn   (pinIn[g]),
        .pinOut  (pinOut[g]),
        .pinOe   (pinOe[g]),
        .readVal (readVal[g])
      );

      if (g == pcfg_pkg::SLOT_P13) begin : gSeg13
        assign segSel[g]   = segQ[0];
        assign segDrive[g] = segData13;
      end else if (g == pcfg_pkg::SLOT_P14) begin : gSeg14
        assign segSel[g]   = segQ[1];
        assign segDrive[g] = segData14;
      end else begin : gNoSeg
        assign segSel[g]   = 8'h00;
        assign segDrive[g] = 8'h00;
      end
    end

    for (g = 0; g < pcfg_pkg::NPU; g++) begin : gPu
      pcfg_sfr_reg #(
        .ADDR (pcfg_pkg::PU_ADDR[g]),
        .RST  (pcfg_pkg::PU_RESET)
      ) uPu (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .req     (sfrReq),
        .hit     (puHit[g]),
        .q       (puQ[g])
      ); // R4 R3
      assign pullupEn[g] = puQ[g]; // R5 R6 R9
    end

    for (g = 0; g < pcfg_pkg::NSEG; g++) begin : gSegReg
      pcfg_sfr_reg #(
        .ADDR       (pcfg_pkg::SEG_ADDR[g]),
        .RST        (pcfg_pkg::SEG_RESET),
        .WHOLE_ONLY (1'b1)
      ) uSeg (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .req     (sfrReq),
        .hit     (segHit[g]),
        .q       (segQ[g])
      ); // R17
    end
  endgenerate

  assign port1Hit = (sfrReq.addr == pcfg_pkg::PORT1_ADDR); // R13

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    for (int i = 0; i < pcfg_pkg::NPORT; i++) begin
      if (dirHit[i])   rdata_d = rdata_d | dirQ[i];
      if (latchHit[i]) rdata_d = rdata_d | readVal[i]; // R18
    end
    for (int i = 0; i < pcfg_pkg::NPU; i++) begin
      if (puHit[i]) rdata_d = rdata_d | puQ[i];
    end
    for (int i = 0; i < pcfg_pkg::NSEG; i++) begin
      if (segHit[i]) rdata_d = rdata_d | segQ[i];
    end
    if (port1Hit) rdata_d = rdata_d | port1Pins; // R13
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_q   <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= sfrReq.rd;
      if (sfrReq.rd) rdata_q <= rdata_d;
    end
  end

  assign sfrRdata   = rdata_q;
  assign sfrRdValid = rdValid_q;

  // port 0 pins feed interrupt detection whatever drives them
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      p0Prev_q   <= 8'h00;
      p0Primed_q <= 1'b0;
      intReq_q   <= 8'h00;
    end else begin
      p0Prev_q   <= pinIn[pcfg_pkg::SLOT_P0];
      p0Primed_q <= 1'b1;
      intReq_q   <= p0Primed_q ? (pinIn[pcfg_pkg::SLOT_P0] ^ p0Prev_q) : 8'h00; // R14
    end
  end

  assign port0IntReq = intReq_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  dir_reset_a: assert property (disable iff (1'b0) !rst_n |=> dirQ == {10{8'hFF}}) // R2
    else $error("direction registers not all ones after reset");
  pu_reset_a: assert property (disable iff (1'b0) !rst_n |=> puQ == '0 && pullupEn == '0) // R4
    else $error("pull-up selects not clear after reset");
  p13_input_a: assert property (disable iff (1'b0) !rst_n |=> pinOe[8] == 8'h00) // R11
    else $error("port 13 driving after reset");
  oe_dir_a: assert property (pinOe[0] == ~dirQ[0] && pinOe[9] == (segQ[1] | ~dirQ[9])) // R1
    else $error("output enable does not follow direction");
  dir_byte_a: assert property (sfrReq.wr && !sfrReq.bitOp && sfrReq.addr == 16'hFF2D // R3
    |=> dirQ[8] == $past(sfrReq.wdata) && $stable(dirQ[0]))
    else $error("direction byte write not taken alone");
  dir_bit_a: assert property (sfrReq.wr && sfrReq.bitOp && sfrReq.addr == 16'hFF27 // R3
    |=> dirQ[6][$past(sfrReq.bitSel)] == $past(sfrReq.wdata[0])
        && ((dirQ[6] ^ $past(dirQ[6])) & ~(8'h01 << $past(sfrReq.bitSel))) == 8'h00)
    else $error("direction bit write disturbed other bits");
  fixed_ones_a: assert property (dirQ[1][7] && dirQ[2][7:5] == 3'b111 // R20
    && (dirQ[5] & 8'h4F) == 8'h4F)
    else $error("fixed direction bit lost");
  pu_follow_a: assert property (sfrReq.wr && !sfrReq.bitOp && sfrReq.addr == 16'hFF3D // R6 R9
    |=> pullupEn[3] == $past(sfrReq.wdata))
    else $error("port 13 pull-up not following select");
  seg_whole_a: assert property (sfrReq.wr && sfrReq.addr == 16'hFF5D // R17
    && sfrReq.wdata != 8'h00 && sfrReq.wdata != 8'hFF |=> $stable(segQ[0]))
    else $error("segment select took a partial value");
  seg_bit_a: assert property (sfrReq.wr && sfrReq.bitOp && sfrReq.addr == 16'hFF5D // R17
    |=> $stable(segQ[0]))
    else $error("segment select took a bit write");
  seg_route_a: assert property (segQ[0] == 8'hFF |-> pinOe[8] == 8'hFF // R17
    && pinOut[8] == segData13)
    else $error("port 13 not routed to segments");
  latch_wr_a: assert property (sfrReq.wr && !sfrReq.bitOp && sfrReq.addr == 16'hFF00 // R19
    |=> latchQ[0] == $past(sfrReq.wdata) && (pinOut[0] & pinOe[0]) == (latchQ[0] & ~dirQ[0]))
    else $error("latch write or pin drive wrong");
  read_mix_a: assert property (sfrReq.rd && sfrReq.addr == 16'hFF0E // R18
    |=> sfrRdValid && sfrRdata == (($past(dirQ[9]) & $past(pinIn[9]))
        | (~$past(dirQ[9]) & $past(latchQ[9]))) && $stable(latchQ[9]))
    else $error("port read value wrong");
  rd_valid_a: assert property (sfrRdValid == $past(sfrReq.rd)) // R18
    else $error("read valid not one cycle after read");
  p1_read_a: assert property (sfrReq.rd && sfrReq.addr == 16'hFF01 // R13
    |=> sfrRdata == $past(port1Pins))
    else $error("port 1 read wrong");
  irq_edge_a: assert property (p0Primed_q && pinIn[0] != p0Prev_q // R14
    |=> port0IntReq == $past(pinIn[0] ^ p0Prev_q))
    else $error("port 0 change not flagged");

  bit_write_c: cover property (sfrReq.wr && sfrReq.bitOp && dirHit != '0);
  seg_on_c:    cover property (segQ[1] == 8'hFF);
  irq_c:       cover property (port0IntReq != 8'h00 && dirQ[0] != 8'hFF);
  pu_out_c:    cover property (pullupEn[0] != 8'h00 && dirQ[0] != 8'hFF);
endmodule
`default_nettype wire

//--- bench/pcfg_pin_model.sv
// pin-side model: resolves each pin from the block, the bench driver and the pull-ups
// assumes slots and pull-up indices as laid out in pcfg_pkg
`default_nettype none
module pcfg_pin_model (
  input  wire logic                     clk_sys,  // system clock
  input  wire pcfg_pkg::pcfg_pins_t     pinOut,   // block drive levels
  input  wire pcfg_pkg::pcfg_pins_t     pinOe,    // block drive enables
  input  wire pcfg_pkg::pcfg_pins_t     extLvl,   // external drive levels
  input  wire pcfg_pkg::pcfg_pins_t     extEn,    // external drive enables
  input  wire logic [pcfg_pkg::NPU-1:0][7:0] pullupEn, // pull-up connects
  output pcfg_pkg::pcfg_pins_t          pinIn     // resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flipQ = 1'b0;
  always @(posedge clk_sys) flipQ <= ~flipQ;
  always_comb begin
    for (int s = 0; s < pcfg_pkg::NPORT; s++) begin
      for (int b = 0; b < 8; b++) begin
        // an undriven pin without pull-up wanders every cycle
        pinIn[s][b] = flipQ ^ b[0];
        for (int k = 0; k < pcfg_pkg::NPU; k++) begin
          if (pcfg_pkg::PU_SLOT[k] == s && pullupEn[k][b]) pinIn[s][b] = 1'b1;
        end
        if (extEn[s][b]) pinIn[s][b] = extLvl[s][b];
        if (pinOe[s][b]) pinIn[s][b] = pinOut[s][b];
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/tb_pcfg_port_ctrl.sv
// self-checking bench of the port direction and pull-up control block
// assumes pcfg_pin_model stands on the pins
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_pcfg_port_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk_sys = 1'b0;
  logic                    rst_n = 1'b0;
  pcfg_pkg::pcfg_sfr_req_t sfrReq = '0;
  logic [7:0]              sfrRdata;
  logic                    sfrRdValid;
  pcfg_pkg::pcfg_pins_t    pinIn, pinOut, pinOe;
  pcfg_pkg::pcfg_pins_t    extLvl = '0;
  pcfg_pkg::pcfg_pins_t    extEn = '1;
  logic [7:0]              port1Pins = 8'h00;
  logic [pcfg_pkg::NPU-1:0][7:0] pullupEn;
  logic [7:0]              segData13 = 8'h00;
  logic [7:0]              segData14 = 8'h00;
  logic [7:0]              port0IntReq;
  int                      num_errors = 0;
  int                      tests_run = 0;
  int                      i;

  always #5 clk_sys = ~clk_sys;

  pcfg_port_ctrl u_pcfg_port_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .sfrReq(sfrReq),
    .sfrRdata(sfrRdata), .sfrRdValid(sfrRdValid), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .port1Pins(port1Pins), .pullupEn(pullupEn), .segData13(segData13),
    .segData14(segData14), .port0IntReq(port0IntReq));
  pcfg_pin_model u_pcfg_pin_model (.clk_sys(clk_sys), .pinOut(pinOut), .pinOe(pinOe),
    .extLvl(extLvl), .extEn(extEn), .pullupEn(pullupEn), .pinIn(pinIn));

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bo = 1'b0,
                    input logic [2:0] bs = 3'h0);
    // an idle edge first keeps the last call's clear apart from this request
    @(posedge clk_sys);
    #1 sfrReq = '{addr: a, wr: 1'b1, rd: 1'b0, bitOp: bo, bitSel: bs, wdata: d};
    @(posedge clk_sys);
    #1 sfrReq.wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    #1 sfrReq = '{addr: a, wr: 1'b0, rd: 1'b1, bitOp: 1'b0, bitSel: 3'h0, wdata: 8'h00};
    @(posedge clk_sys);
    #1 sfrReq.rd = 1'b0;
    `CHK(sfrRdValid, 1'b1)
    `CHK(sfrRdata, e)
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100us;
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    `CHK(pinOe, '0)
    `CHK(pullupEn, '0)
    for (i = 0; i < pcfg_pkg::NPORT; i++) rd(pcfg_pkg::DIR_ADDR[i], pcfg_pkg::DIR_RESET);
    for (i = 0; i < pcfg_pkg::NPU; i++) rd(pcfg_pkg::PU_ADDR[i], pcfg_pkg::PU_RESET);
    for (i = 0; i < pcfg_pkg::NPORT; i++) wr(pcfg_pkg::DIR_ADDR[i], 8'h5A ^ 8'(i));
    for (i = 0; i < pcfg_pkg::NPORT; i++)
      rd(pcfg_pkg::DIR_ADDR[i], (8'h5A ^ 8'(i)) | pcfg_pkg::DIR_FIXED1[i]);
    wr(pcfg_pkg::DIR_ADDR[pcfg_pkg::SLOT_P13], 8'h01, 1'b1, 3'h7);
    rd(pcfg_pkg::DIR_ADDR[pcfg_pkg::SLOT_P13], 8'hD2);
    wr(pcfg_pkg::DIR_ADDR[6], 8'h00, 1'b1, 3'h2);
    rd(pcfg_pkg::DIR_ADDR[6], 8'h58);
    wr(pcfg_pkg::DIR_ADDR[pcfg_pkg::SLOT_P0], 8'h0F);
    `CHK(pinOe[pcfg_pkg::SLOT_P0], 8'hF0)
    // port 13: low nibble input from outside, high nibble driven from the latch
    wr(pcfg_pkg::DIR_ADDR[pcfg_pkg::SLOT_P13], 8'h0F);
    wr(pcfg_pkg::LATCH_ADDR[pcfg_pkg::SLOT_P13], 8'hA5);
    extLvl[pcfg_pkg::SLOT_P13] = 8'h3C;
    `CHK(pinOe[pcfg_pkg::SLOT_P13], 8'hF0)
    `CHK(pinOut[pcfg_pkg::SLOT_P13] & pinOe[pcfg_pkg::SLOT_P13], 8'hA0)
    rd(pcfg_pkg::LATCH_ADDR[pcfg_pkg::SLOT_P13], 8'hAC);
    rd(pcfg_pkg::LATCH_ADDR[pcfg_pkg::SLOT_P13], 8'hAC);
    wr(pcfg_pkg::DIR_ADDR[pcfg_pkg::SLOT_P14], 8'hFF);
    wr(pcfg_pkg::LATCH_ADDR[pcfg_pkg::SLOT_P14], 8'hFF);
    `CHK(pinOe[pcfg_pkg::SLOT_P14], 8'h00)
    wr(pcfg_pkg::DIR_ADDR[pcfg_pkg::SLOT_P14], 8'h00);
    `CHK(pinOe[pcfg_pkg::SLOT_P14] & pinOut[pcfg_pkg::SLOT_P14], 8'hFF)
    rd(pcfg_pkg::LATCH_ADDR[pcfg_pkg::SLOT_P14], 8'hFF);
    for (i = 0; i < pcfg_pkg::NPU; i++) begin
      wr(pcfg_pkg::PU_ADDR[i], 8'hC3 ^ 8'(i));
      rd(pcfg_pkg::PU_ADDR[i], 8'hC3 ^ 8'(i));
      `CHK(pullupEn[i], 8'hC3 ^ 8'(i))
    end
    // released port 13 pins must read high through their pull-ups
    wr(pcfg_pkg::PU_ADDR[3], 8'hFF);
    wr(pcfg_pkg::DIR_ADDR[pcfg_pkg::SLOT_P13], 8'hFF);
    extEn[pcfg_pkg::SLOT_P13] = 8'h00;
    rd(pcfg_pkg::LATCH_ADDR[pcfg_pkg::SLOT_P13], 8'hFF);
    extEn[pcfg_pkg::SLOT_P13] = 8'hFF;
    wr(pcfg_pkg::DIR_ADDR[pcfg_pkg::SLOT_P13], 8'h00);
    `CHK(pullupEn[3], 8'hFF)
    // software drops the pull-ups of pins it has turned to output
    wr(pcfg_pkg::PU_ADDR[3], 8'h00);
    `CHK(pullupEn[3], 8'h00)
    port1Pins = 8'h96;
    wr(pcfg_pkg::PORT1_ADDR, 8'h00);
    rd(pcfg_pkg::PORT1_ADDR, 8'h96);
    rd(16'hFF10, 8'h00);
    segData13 = 8'h3C;
    segData14 = 8'hC3;
    wr(pcfg_pkg::SEG_ADDR[0], pcfg_pkg::SEG_ALL);
    `CHK(pinOe[pcfg_pkg::SLOT_P13] & pinOut[pcfg_pkg::SLOT_P13], 8'h3C)
    wr(pcfg_pkg::SEG_ADDR[0], 8'h5A);
    wr(pcfg_pkg::SEG_ADDR[0], 8'h00, 1'b1, 3'h0);
    rd(pcfg_pkg::SEG_ADDR[0], pcfg_pkg::SEG_ALL);
    wr(pcfg_pkg::SEG_ADDR[1], pcfg_pkg::SEG_ALL);
    `CHK(pinOut[pcfg_pkg::SLOT_P14], 8'hC3)
    wr(pcfg_pkg::SEG_ADDR[0], pcfg_pkg::SEG_NONE);
    `CHK(pinOut[pcfg_pkg::SLOT_P13], 8'hA5)
    wr(pcfg_pkg::DIR_ADDR[pcfg_pkg::SLOT_P0], 8'h00);
    wr(pcfg_pkg::LATCH_ADDR[pcfg_pkg::SLOT_P0], 8'h01);
    for (i = 0; i < 5 && port0IntReq !== 8'h01; i++) @(posedge clk_sys) #1;
    `CHK(port0IntReq, 8'h01)
    // the request is a single-cycle pulse
    @(posedge clk_sys) #1;
    `CHK(port0IntReq, 8'h00)
    rst_n = 1'b0;
    @(posedge clk_sys);
    #1 rst_n = 1'b1;
    `CHK(pinOe, '0)
    `CHK(pullupEn, '0)
    stop_test();
  end
endmodule
`default_nettype wire
